/* shared/rtmr_pkg.sv */
// Purpose: constants and types for the reload timer control register block
// Assumes: byte-wide register port, printed addresses used as-is
package rtmr_pkg;
   localparam logic [19:0] ADDR_CTRL = 20'hf0240;
   localparam logic [19:0] ADDR_IOC = 20'hf0241;
   localparam logic [19:0] ADDR_MODE = 20'hf0242;
   localparam logic [19:0] ADDR_GATE = 20'hf0243;
   localparam logic [19:0] ADDR_PM0 = 20'hfff20;
   localparam logic [19:0] ADDR_PM3 = 20'hfff23;
   localparam logic [19:0] ADDR_PM4 = 20'hfff24;
   localparam logic [19:0] ADDR_PM5 = 20'hfff25;
   localparam logic [7:0] RST_TIMER = 8'h00;
   localparam logic [7:0] RST_PM = 8'hff;
   localparam logic [7:0] PM_FIXED = 8'hfc;
   // bit positions in the control/status register
   localparam int BIT_UNDF = 5;
   localparam int BIT_EDGF = 4;
   localparam int BIT_STOP = 2;
   localparam int BIT_CSTF = 1;
   localparam int BIT_RUN = 0;
   localparam logic [7:0] MASK_IOC = 8'hf5;
   localparam logic [7:0] MASK_MODE = 8'h7f;
   localparam logic [7:0] MASK_GATE = 8'h07;
   localparam logic [2:0] MODE_TIMER = 3'h0;
   localparam logic [2:0] MODE_PULSE = 3'h1;
   localparam logic [2:0] MODE_EVENT = 3'h2;
   localparam logic [2:0] MODE_WIDTH = 3'h3;
   localparam logic [2:0] MODE_PERIOD = 3'h4;
   localparam logic [2:0] SRC_FCLK = 3'h0;
   localparam logic [2:0] SRC_DIV8 = 3'h1;
   localparam logic [2:0] SRC_DIV2 = 3'h3;
   localparam logic [2:0] SRC_LOSC = 3'h4;
   localparam logic [2:0] SRC_ELC = 3'h5;
   localparam logic [4:0] FILT_DIV8 = 5'h07;
   localparam logic [4:0] FILT_DIV32 = 5'h1f;
   localparam logic [2:0] DIV8_LAST = 3'h7;
   localparam logic [1:0] FILT_MATCH = 2'h2;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [19:0] addr;
      logic [7:0] wdata;
   } cpu_req_s;
   typedef struct packed {
      logic underflow;
      logic meas_done;
      logic period_edge;
   } cnt_evt_s;
   typedef enum logic [1:0] {
      RUN_IDLE = 2'b01,
      RUN_ON = 2'b10
   } run_e;
endpackage : rtmr_pkg

/* hdl/reload_timer_control_regs.sv */
// Purpose: control, I/O, mode and gate registers of a reload down-counter timer
// Assumes: cpu request is synchronous, one-cycle strobes; counter datapath outside
// Notes: read data registered one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module reload_timer_control_regs
   import rtmr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire cpu_req_s cpu_req,
   input wire logic timer_clock_enable,
   input wire cnt_evt_s cnt_evt,
   input wire logic timer_bidir_pin_in,
   input wire logic external_gate_irq_pin,
   input wire logic [3:0] gate_sources,
   input wire logic low_osc_clk_tick,
   input wire logic event_link_unit_tick,
   output logic [7:0] rdata,
   output logic count_enable,
   output logic count_tick,
   output logic count_status_flag,
   output logic stop_pulse,
   output logic filtered_pin,
   output logic active_edge,
   output logic timer_output_pin,
   output logic timer_output_oe,
   output logic timer_bidir_pin_out,
   output logic timer_bidir_pin_oe,
   output logic [7:0] port0_dir,
   output logic [7:0] port3_dir,
   output logic [7:0] port4_dir,
   output logic [7:0] port5_dir
);
   typedef struct packed {
      logic run;
      logic cstf;
      logic undf;
      logic edgf;
      logic [7:0] ioc;
      logic [7:0] mode;
      logic [7:0] gate;
      logic [7:0] pm0;
      logic [7:0] pm3;
      logic [7:0] pm4;
      logic [7:0] pm5;
      logic [7:0] rdata;
      logic [2:0] div8;
      logic div2;
      logic [4:0] fdiv;
      logic [2:0] samp;
      logic [1:0] fcnt;
      logic fpin;
      logic fpin_d;
      logic tick;
      logic cen;
      logic stop;
      logic aedge;
      logic tout;
      logic tio;
      logic bdoe;
      run_e rs;
   } state_s;

   state_s s_r;
   state_s s_nxt;

   logic wr_ctrl;
   logic wr_ioc;
   logic wr_mode;
   logic wr_gate;
   logic [2:0] op_mode;
   logic [2:0] src;
   logic pol;
   logic both_edge_count;
   logic [1:0] event_gate_mode;
   logic [1:0] input_filter_sel;
   logic gate_level_select;
   logic [1:0] gate_source_sel;
   logic samp_en;
   logic rise;
   logic fall;
   logic edge_hit;
   logic gate_sig;
   logic gate_ok;
   logic src_tick;
   logic stop_req;

   // timer register writes are dropped while the peripheral clock is off
   assign wr_ctrl = cpu_req.wr && timer_clock_enable && cpu_req.addr == ADDR_CTRL;
   assign wr_ioc = cpu_req.wr && timer_clock_enable && cpu_req.addr == ADDR_IOC;
   assign wr_mode = cpu_req.wr && timer_clock_enable && cpu_req.addr == ADDR_MODE;
   assign wr_gate = cpu_req.wr && timer_clock_enable && cpu_req.addr == ADDR_GATE;
   assign stop_req = wr_ctrl && cpu_req.wdata[BIT_STOP];

   // field views
   assign op_mode = s_r.mode[2:0];
   assign both_edge_count = s_r.mode[3];
   assign src = s_r.mode[6:4];
   assign pol = s_r.ioc[0];
   assign input_filter_sel = s_r.ioc[5:4];
   assign event_gate_mode = s_r.ioc[7:6];
   assign gate_level_select = s_r.gate[2];
   assign gate_source_sel = s_r.gate[1:0];

   // filter sample strobe per select code
   always_comb begin
      unique case (input_filter_sel)
         2'h0: samp_en = 1'b1;
         2'h1: samp_en = 1'b1;
         2'h2: samp_en = s_r.fdiv[2:0] == FILT_DIV8[2:0];
         2'h3: samp_en = s_r.fdiv == FILT_DIV32;
      endcase
   end

   // pin edges, polarity and both-edge choice
   assign rise = s_r.fpin && !s_r.fpin_d;
   assign fall = !s_r.fpin && s_r.fpin_d;
   assign edge_hit = both_edge_count ? (rise || fall) : (pol ? fall : rise);

   // gating signal, only meaningful in event mode
   assign gate_sig = (event_gate_mode == 2'h1) ? external_gate_irq_pin
                   : gate_sources[gate_source_sel];
   assign gate_ok = (event_gate_mode == 2'h0) ||
                    (event_gate_mode != 2'h3 && gate_sig == gate_level_select);

   // count source; event mode overrides the select field
   always_comb begin
      if (op_mode == MODE_EVENT) begin
         src_tick = edge_hit && gate_ok;
      end else begin
         unique case (src)
            SRC_FCLK: src_tick = 1'b1;
            SRC_DIV8: src_tick = s_r.div8 == DIV8_LAST;
            SRC_DIV2: src_tick = s_r.div2;
            SRC_LOSC: src_tick = low_osc_clk_tick;
            SRC_ELC: src_tick = event_link_unit_tick;
            default: src_tick = 1'b0; // prohibited codes never tick
         endcase
      end
   end

   // next-state logic for the whole block
   always_comb begin
      s_nxt = s_r;
      s_nxt.stop = 1'b0;
      s_nxt.aedge = 1'b0;
      s_nxt.div8 = s_r.div8 + 3'h1;
      s_nxt.div2 = !s_r.div2;
      s_nxt.fdiv = s_r.fdiv + 5'h01;
      s_nxt.tick = src_tick;
      // input filter: three matching samples accept a new level
      if (input_filter_sel == 2'h0) begin
         s_nxt.fpin = timer_bidir_pin_in;
         s_nxt.fcnt = 2'h0;
      end else if (samp_en) begin
         s_nxt.samp = {s_r.samp[1:0], timer_bidir_pin_in};
         if (timer_bidir_pin_in != s_r.samp[0]) begin
            s_nxt.fcnt = 2'h0;
         end else begin
            if (s_r.fcnt != FILT_MATCH) begin
               s_nxt.fcnt = s_r.fcnt + 2'h1;
            end
            // third matching sample in a row takes the level
            if (s_r.fcnt != 2'h0) begin
               s_nxt.fpin = timer_bidir_pin_in;
            end
         end
      end
      s_nxt.fpin_d = s_r.fpin;
      // measurement edges for width and period modes
      if (op_mode == MODE_WIDTH) begin
         s_nxt.aedge = pol ? fall : rise;
      end else if (op_mode == MODE_PERIOD) begin
         s_nxt.aedge = pol ? fall : rise;
      end
      // flags: hardware set beats a software clear in the same cycle
      if (wr_ctrl && !cpu_req.wdata[BIT_UNDF]) begin
         s_nxt.undf = 1'b0;
      end
      if (cnt_evt.underflow) begin
         s_nxt.undf = 1'b1;
      end
      if (wr_ctrl && !cpu_req.wdata[BIT_EDGF]) begin
         s_nxt.edgf = 1'b0;
      end
      if ((cnt_evt.meas_done && op_mode == MODE_WIDTH) ||
          (cnt_evt.period_edge && op_mode == MODE_PERIOD)) begin
         s_nxt.edgf = 1'b1;
      end
      // run request and status flag following the count source
      if (wr_ctrl) begin
         s_nxt.run = cpu_req.wdata[BIT_RUN];
      end
      unique case (s_r.rs)
         RUN_IDLE: begin
            if (s_r.run && src_tick) begin
               s_nxt.rs = RUN_ON;
               s_nxt.cstf = 1'b1;
            end
         end
         RUN_ON: begin
            if (!s_r.run && src_tick) begin
               s_nxt.rs = RUN_IDLE;
               s_nxt.cstf = 1'b0;
            end
         end
      endcase
      s_nxt.cen = s_nxt.cstf;
      // pulse toggles on underflow in every mode except the plain timer mode
      if (s_r.cstf && cnt_evt.underflow && op_mode != MODE_TIMER) begin
         s_nxt.tout = !s_r.tout;
         s_nxt.tio = !s_r.tio;
      end
      if (wr_ioc) begin
         s_nxt.ioc = cpu_req.wdata & MASK_IOC;
      end
      if (wr_gate) begin
         s_nxt.gate = cpu_req.wdata & MASK_GATE;
      end
      // mode write reloads both output levels from the polarity bit
      if (wr_mode) begin
         s_nxt.mode = cpu_req.wdata & MASK_MODE;
         s_nxt.tout = s_nxt.ioc[0];
         s_nxt.tio = !s_nxt.ioc[0];
      end
      // forced stop wins over every other run or status update
      if (stop_req) begin
         s_nxt.run = 1'b0;
         s_nxt.cstf = 1'b0;
         s_nxt.cen = 1'b0;
         s_nxt.rs = RUN_IDLE;
         s_nxt.stop = 1'b1;
         s_nxt.tout = s_nxt.ioc[0];
         s_nxt.tio = !s_nxt.ioc[0];
      end
      // port direction registers stay writable without the timer clock
      if (cpu_req.wr && cpu_req.addr == ADDR_PM0) begin
         s_nxt.pm0 = cpu_req.wdata | PM_FIXED;
      end
      if (cpu_req.wr && cpu_req.addr == ADDR_PM3) begin
         s_nxt.pm3 = cpu_req.wdata | PM_FIXED;
      end
      if (cpu_req.wr && cpu_req.addr == ADDR_PM4) begin
         s_nxt.pm4 = cpu_req.wdata | PM_FIXED;
      end
      if (cpu_req.wr && cpu_req.addr == ADDR_PM5) begin
         s_nxt.pm5 = cpu_req.wdata | PM_FIXED;
      end
      // read mux; forced-stop bit always reads 0, timer registers read defaults with the clock off
      s_nxt.rdata = 8'h00;
      if (cpu_req.rd) begin
         unique case (cpu_req.addr)
            ADDR_CTRL: s_nxt.rdata = {2'h0, s_r.undf, s_r.edgf, 2'h0, s_r.cstf, s_r.run};
            ADDR_IOC: s_nxt.rdata = s_r.ioc;
            ADDR_MODE: s_nxt.rdata = s_r.mode;
            ADDR_GATE: s_nxt.rdata = s_r.gate;
            ADDR_PM0: s_nxt.rdata = s_r.pm0;
            ADDR_PM3: s_nxt.rdata = s_r.pm3;
            ADDR_PM4: s_nxt.rdata = s_r.pm4;
            ADDR_PM5: s_nxt.rdata = s_r.pm5;
            default: s_nxt.rdata = 8'h00;
         endcase
         if (!timer_clock_enable && cpu_req.addr[19:4] == ADDR_CTRL[19:4]) begin
            s_nxt.rdata = RST_TIMER;
         end
      end
      // with the clock off the timer sits in reset
      if (!timer_clock_enable) begin
         s_nxt.run = 1'b0;
         s_nxt.cstf = 1'b0;
         s_nxt.undf = 1'b0;
         s_nxt.edgf = 1'b0;
         s_nxt.ioc = RST_TIMER;
         s_nxt.mode = RST_TIMER;
         s_nxt.gate = RST_TIMER;
         s_nxt.rs = RUN_IDLE;
         s_nxt.cen = 1'b0;
         s_nxt.tout = 1'b0;
         s_nxt.tio = 1'b1;
      end
      // bidir drive enable registered so the pin comes from a flop
      s_nxt.bdoe = s_nxt.mode[2:0] == MODE_PULSE && s_nxt.pm0[1] == 1'b0;
   end

   // single state register, frozen while the clock enable is low
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '0;
         s_r.pm0 <= RST_PM;
         s_r.pm3 <= RST_PM;
         s_r.pm4 <= RST_PM;
         s_r.pm5 <= RST_PM;
         s_r.tio <= 1'b1;
         s_r.rs <= RUN_IDLE;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from state flops
   assign rdata = s_r.rdata;
   assign count_enable = s_r.cen;
   assign count_tick = s_r.tick;
   assign count_status_flag = s_r.cstf;
   assign stop_pulse = s_r.stop;
   assign filtered_pin = s_r.fpin;
   assign active_edge = s_r.aedge;
   assign timer_output_pin = s_r.tout;
   assign timer_output_oe = s_r.ioc[2];
   assign timer_bidir_pin_out = s_r.tio;
   assign timer_bidir_pin_oe = s_r.bdoe;
   assign port0_dir = s_r.pm0;
   assign port3_dir = s_r.pm3;
   assign port4_dir = s_r.pm4;
   assign port5_dir = s_r.pm5;

   // underflow flag rises the cycle after an underflow event
   chk_undf_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clk_en && timer_clock_enable && cnt_evt.underflow |=> s_r.undf)
      else $error("underflow flag not set");
   // flag only falls on a zero write or with the timer clock off
   chk_undf_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $fell(s_r.undf) |-> $past(wr_ctrl && !cpu_req.wdata[BIT_UNDF]) || !$past(timer_clock_enable))
      else $error("underflow flag cleared without zero write");
   chk_edge_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clk_en && timer_clock_enable && cnt_evt.period_edge && op_mode == MODE_PERIOD
      |=> s_r.edgf)
      else $error("active edge flag not set");
   chk_stop_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clk_en && stop_req |=> !s_r.run && !s_r.cstf && s_r.tout == s_r.ioc[0])
      else $error("forced stop did not clear run state");
   chk_stop_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clk_en && cpu_req.rd && cpu_req.addr == ADDR_CTRL |=> !s_r.rdata[BIT_STOP])
      else $error("forced stop bit read back as one");
   chk_cstf_sync: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(s_r.cstf) |-> $past(s_r.run && src_tick))
      else $error("status flag rose without count tick");
   chk_mode_init: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clk_en && wr_mode && !stop_req |=> s_r.tout == s_r.ioc[0] && s_r.tio != s_r.ioc[0])
      else $error("mode write did not reinit outputs");
   chk_off_ignore: assert property (@(posedge ref_clk) disable iff (!rst_b)
      clk_en && !timer_clock_enable ##1 clk_en && !timer_clock_enable |-> s_r.mode == RST_TIMER)
      else $error("timer register changed with clock off");
endmodule : reload_timer_control_regs
`default_nettype wire

/* testbench/pulse_source_model.sv */
// Purpose: far-side model: event pin level, gate levels, slow source ticks
// Assumes: levels change just after a clock edge
// Notes: gate levels walk a free counter, ticks are periodic
`timescale 1ns/1ps
`default_nettype none
module pulse_source_model (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ext_level,
   input wire logic pin_oe,
   input wire logic pin_out,
   output logic pin_in,
   output logic irq_level,
   output logic [3:0] gate_lv,
   output logic losc_tick,
   output logic link_tick
);
   logic [5:0] cnt_r;
   // free divider; slow oscillator ticks every 32 cycles, link every 8
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 6'h00;
      end else begin
         cnt_r <= cnt_r + 6'h01;
      end
   end
   // the wire shows the design drive when enabled, else the far source
   assign pin_in = pin_oe ? pin_out : ext_level;
   assign irq_level = cnt_r[5];
   assign gate_lv = cnt_r[5:2];
   assign losc_tick = (cnt_r[4:0] == 5'h1f);
   assign link_tick = (cnt_r[2:0] == 3'h3);
endmodule : pulse_source_model
`default_nettype wire

/* testbench/test_reload_timer_control_regs.sv */
// Purpose: self-checking bench for the timer control registers
// Assumes: counter datapath events driven here as one-cycle pulses
// Notes: gating of event counts is checked only for the prohibited gate code
`timescale 1ns/1ps
`default_nettype none
module test_reload_timer_control_regs;
   import rtmr_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   cpu_req_s cpu_req = '0;
   logic timer_clock_enable = 1'b1;
   cnt_evt_s cnt_evt = '0;
   logic ext_level = 1'b0;
   logic pin_in, irq_level, losc_tick, link_tick, count_enable, count_tick;
   logic count_status_flag, stop_pulse, filtered_pin, active_edge;
   logic out_pin, out_oe, bd_out, bd_oe;
   logic [3:0] gate_lv;
   logic [7:0] rdata, p0, p3, p4, p5, rv, ticks;
   logic [19:0] ra;
   logic [31:0] rng = 32'hd747;
   logic [19:0] addrs [8] = '{ADDR_CTRL, ADDR_IOC, ADDR_MODE, ADDR_GATE,
                              ADDR_PM0, ADDR_PM3, ADDR_PM4, ADDR_PM5};
   logic [2:0] srcs [4] = '{SRC_DIV8, SRC_DIV2, SRC_LOSC, SRC_ELC};
   logic [7:0] exp_t [3] = '{8'h04, 8'h03, 8'h07};
   int n_fail = 0;
   int check_count = 0;

   reload_timer_control_regs reload_timer_control_regs_inst (
      .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .cpu_req(cpu_req),
      .timer_clock_enable(timer_clock_enable), .cnt_evt(cnt_evt),
      .timer_bidir_pin_in(pin_in), .external_gate_irq_pin(irq_level),
      .gate_sources(gate_lv), .low_osc_clk_tick(losc_tick),
      .event_link_unit_tick(link_tick), .rdata(rdata), .count_enable(count_enable),
      .count_tick(count_tick), .count_status_flag(count_status_flag),
      .stop_pulse(stop_pulse), .filtered_pin(filtered_pin), .active_edge(active_edge),
      .timer_output_pin(out_pin), .timer_output_oe(out_oe),
      .timer_bidir_pin_out(bd_out), .timer_bidir_pin_oe(bd_oe),
      .port0_dir(p0), .port3_dir(p3), .port4_dir(p4), .port5_dir(p5));

   pulse_source_model pulse_source_model_inst (
      .ref_clk(ref_clk), .rst_b(rst_b), .ext_level(ext_level), .pin_oe(bd_oe),
      .pin_out(bd_out), .pin_in(pin_in), .irq_level(irq_level), .gate_lv(gate_lv),
      .losc_tick(losc_tick), .link_tick(link_tick));

   always #25 ref_clk = ~ref_clk;

   // tick counter sampled off the active edge to avoid races
   always @(negedge ref_clk) begin
      if (count_tick === 1'b1) begin
         ticks = ticks + 8'h01;
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // readback of a written byte: reserved bits dropped, direction bits 7:2 fixed
   function automatic logic [7:0] reg_view(input logic [19:0] a, input logic [7:0] d);
      case (a)
         ADDR_IOC: return d & MASK_IOC;
         ADDR_MODE: return d & MASK_MODE;
         ADDR_GATE: return d & MASK_GATE;
         ADDR_PM0, ADDR_PM3, ADDR_PM4, ADDR_PM5: return d | PM_FIXED;
         default: return 8'h00;
      endcase
   endfunction : reg_view

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      cpu_req <= {1'b1, 1'b0, a, d};
      @(posedge ref_clk);
      cpu_req <= '0;
   endtask : wr

   // read data stands for one cycle after the strobe edge
   task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      cpu_req <= {1'b0, 1'b1, a, 8'h00};
      @(posedge ref_clk);
      cpu_req <= '0;
      #1 check(rdata, exp);
   endtask : rd_chk

   // status follows a source tick, so wait a bounded span for it
   task automatic wait_flag(input logic v);
      for (int i = 0; i < 40 && count_status_flag !== v; i++) @(posedge ref_clk);
      #1 check({7'h00, count_status_flag}, {7'h00, v});
   endtask : wait_flag

   task automatic evt(input cnt_evt_s e);
      @(posedge ref_clk);
      cnt_evt <= e;
      @(posedge ref_clk);
      cnt_evt <= '0;
   endtask : evt

   task automatic pin(input logic v);
      @(posedge ref_clk);
      ext_level <= v;
      repeat (8) @(posedge ref_clk);
   endtask : pin

   task automatic end_sim;
      if (n_fail == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      foreach (addrs[i]) rd_chk(addrs[i], (i < 4) ? RST_TIMER : RST_PM);
      rd_chk(20'hf0244, 8'h00);
      // random bytes into every register but control; all stopped here
      for (int k = 0; k < 40; k++) begin
         rng = lfsr(rng);
         ra = addrs[1 + (rng[10:8] % 7)];
         rv = rng[7:0];
         wr(ra, rv);
         rd_chk(ra, reg_view(ra, rv));
      end
      // clock gated off: timer writes lost, direction registers still live
      @(posedge ref_clk);
      timer_clock_enable <= 1'b0;
      wr(ADDR_IOC, 8'hf5);
      rd_chk(ADDR_IOC, 8'h00);
      wr(ADDR_PM3, 8'h00);
      rd_chk(ADDR_PM3, 8'hfc);
      @(posedge ref_clk);
      timer_clock_enable <= 1'b1;
      rd_chk(ADDR_IOC, 8'h00);
      // start and forced stop from the plain clock
      wr(ADDR_MODE, {1'b0, SRC_FCLK, 1'b0, MODE_TIMER});
      wr(ADDR_CTRL, 8'h01);
      wait_flag(1'b1);
      rd_chk(ADDR_CTRL, 8'h03);
      wr(ADDR_CTRL, 8'h05);
      #1 check({count_enable, stop_pulse, count_status_flag}, 8'h02);
      rd_chk(ADDR_CTRL, 8'h00);
      // every other source; low oscillator permit assumed granted upstream
      foreach (srcs[i]) begin
         wr(ADDR_MODE, {1'b0, srcs[i], 1'b0, MODE_TIMER});
         wr(ADDR_CTRL, 8'h01);
         wait_flag(1'b1);
         wr(ADDR_CTRL, 8'h00);
         wait_flag(1'b0);
      end
      // flags set by hardware, kept by writing 1, cleared by writing 0
      evt(3'b100);
      rd_chk(ADDR_CTRL, 8'h20);
      wr(ADDR_CTRL, 8'h20);
      rd_chk(ADDR_CTRL, 8'h20);
      wr(ADDR_CTRL, 8'h00);
      rd_chk(ADDR_CTRL, 8'h00);
      wr(ADDR_MODE, {5'h00, MODE_WIDTH});
      evt(3'b010);
      rd_chk(ADDR_CTRL, 8'h10);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_MODE, {5'h00, MODE_PERIOD});
      evt(3'b001);
      rd_chk(ADDR_CTRL, 8'h10);
      wr(ADDR_CTRL, 8'h00);
      rd_chk(ADDR_CTRL, 8'h00);
      // initial output levels after a mode write, both polarities
      wr(ADDR_PM0, 8'hfd);
      for (int p = 0; p < 2; p++) begin
         wr(ADDR_IOC, {7'h02, p[0]});
         wr(ADDR_MODE, {5'h00, MODE_PULSE});
         #1 check({out_oe, out_pin}, {1'b1, p[0]});
         check({bd_oe, bd_out}, {1'b1, ~p[0]});
      end
      wr(ADDR_IOC, 8'h00);
      wr(ADDR_MODE, {5'h00, MODE_TIMER});
      #1 check({out_oe, bd_oe, out_pin}, 8'h00);
      // event counting of pin edges: rising, falling, both
      wr(ADDR_PM0, 8'hff);
      for (int j = 0; j < 3; j++) begin
         wr(ADDR_IOC, (j == 1) ? 8'h01 : 8'h00);
         wr(ADDR_MODE, (j == 2) ? 8'h0a : 8'h02);
         wr(ADDR_CTRL, 8'h01);
         pin(1'b1);
         pin(1'b0);
         wait_flag(1'b1);
         ticks = 8'h00;
         repeat (3) begin
            pin(1'b1);
            pin(1'b0);
         end
         pin(1'b1);
         check({7'h00, filtered_pin}, 8'h01);
         check(ticks, exp_t[j]);
         wr(ADDR_CTRL, 8'h04);
         pin(1'b0);
      end
      // prohibited gate code never lets an edge through
      wr(ADDR_IOC, 8'hc0);
      wr(ADDR_MODE, 8'h02);
      ticks = 8'h00;
      pin(1'b1);
      pin(1'b0);
      check(ticks, 8'h00);
      end_sim();
   end

   // watchdog well beyond the roughly seven hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      end_sim();
   end
endmodule : test_reload_timer_control_regs
`default_nettype wire
